//--- verilog/step_cfg_map.vh
// Purpose: offsets, field positions, reset values and timing counts for the step config bank
// Assumes: 16-bit registers on a plain address/strobe port
// Notes: step two offset 92h, step three offset 93h
`ifndef STEP_CFG_MAP_VH
`define STEP_CFG_MAP_VH

// register offsets (8-bit address)
`define STEP_TWO_CFG_ADDR 8'h92
`define STEP_THREE_CFG_ADDR 8'h93
`define STEP_CTRL_ADDR 8'ha0
`define STEP_STATUS_ADDR 8'ha1

// reset values
`define STEP_TWO_CFG_RST 16'h0002
`define STEP_THREE_CFG_RST 16'h0003

// field positions
`define STEP_EN_BIT 15
`define STEP_GAIN_HI 14
`define STEP_GAIN_LO 13
`define STEP_NEG_BIT 4
`define STEP_POS_HI 3
`define STEP_POS_LO 0

// writable bits of a step register
`define STEP_CFG_WMASK 16'he01f

// gain codes driven to the converter
`define GAIN_X1 2'h0
`define GAIN_X2 2'h1
`define GAIN_X4 2'h2

// positive codes at and above this choose their own negative input
`define POS_AUTO_NEG_FIRST 4'h8

// negative input codes driven to the converter
`define NEG_GROUND 2'h0
`define NEG_INPUT_SEVEN 2'h1
`define NEG_AUTO 2'h2

// conversion time per step: 1000 ns at a 40 ns clock, sized for the counter
`define CONV_CYCLES 10'h019

`endif

//--- verilog/step_cfg_decode.v
// Purpose: turn one stored step register into converter selections
// Assumes: input from a register on the same clock
// Notes: outputs are registered
`timescale 1ns/100ps
`include "step_cfg_map.vh"

module step_cfg_decode (
   // clock and reset
   input wire mclk_i,
   input wire rst_b_i,
   // stored step register
   input wire [15:0] cfg_i,
   // decoded selections
   output reg enable_o,
   output reg [1:0] gain_o,
   output reg [1:0] neg_sel_o,
   output reg [3:0] pos_sel_o
);

   wire [3:0] pos_code;
   reg [1:0] gain_nxt;
   reg [1:0] neg_nxt;

   assign pos_code = cfg_i[`STEP_POS_HI:`STEP_POS_LO];

   // gain and negative input decode
   always @* begin
      case (cfg_i[`STEP_GAIN_HI:`STEP_GAIN_LO])
         2'h0: gain_nxt = `GAIN_X1;
         2'h1: gain_nxt = `GAIN_X2;
         default: gain_nxt = `GAIN_X4; // both 10b and 11b
      endcase
      if (pos_code >= `POS_AUTO_NEG_FIRST) begin
         neg_nxt = `NEG_AUTO; // negative bit ignored
      end else if (cfg_i[`STEP_NEG_BIT]) begin
         neg_nxt = `NEG_INPUT_SEVEN;
      end else begin
         neg_nxt = `NEG_GROUND;
      end
   end

   // registered selections
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         enable_o <= 1'b0;
         gain_o <= `GAIN_X1;
         neg_sel_o <= `NEG_GROUND;
         pos_sel_o <= 4'h0;
      end else begin
         enable_o <= cfg_i[`STEP_EN_BIT];
         gain_o <= gain_nxt;
         neg_sel_o <= neg_nxt;
         pos_sel_o <= pos_code; // inputs 0..7, then internal sources
      end
   end

endmodule // step_cfg_decode

//--- verilog/mux_adc_sequence_step_cfg.v
// Purpose: configuration registers for sequencer steps two and three of the monitor converter
// Assumes: one 25 MHz clock; host port with read data one cycle after the read strobe
// Notes: sequencer runs when run_en is set in the control register
// Notes: the step decode is fed the step held after each edge, so the
//    registered selections seen in pick always belong to the current step,
//    also right after a skipped step or a finished conversion
//
// Overview of operation
// - bit 15 enables the step in the sequence; reset value disables it
// - bits 14:13 pick gain: 00b gives 1, 01b gives 2, 10b/11b give 4
// - bit 4 picks negative input: 0b analog ground, 1b analog input seven
// - bits 3:0 codes 0000b..0111b select analog inputs zero..seven
// - code 1000b temperature sensor, 1001b internal short; negative picked automatically
// - codes 1010b..1111b select internal monitors with automatic negative input
// - negative select bit ignored whenever positive code picks its own negative
// - step three register at 93h, resets to 0003h
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "step_cfg_map.vh"

module mux_adc_sequence_step_cfg (
   // clock and reset
   input wire mclk_i,
   input wire rst_b_i,
   // host register port
   input wire [7:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // converter selections
   output reg conv_start_o,
   output reg [1:0] conv_gain_o,
   output reg [1:0] conv_neg_sel_o,
   output reg [3:0] conv_pos_sel_o,
   output reg [1:0] conv_step_o
);

   // states
   localparam ST_IDLE = 3'b001;
   localparam ST_PICK = 3'b010;
   localparam ST_CONV = 3'b100;

   // reset synchroniser
   reg rst_meta_r;
   reg rst_sync_r;
   wire rst_b;

   // stored step registers and run control
   reg [15:0] step_two_r;
   reg [15:0] step_three_r;
   reg run_en_r;

   // sequencer state
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg cur_step_r;
   reg cur_step_nxt;
   reg start_nxt;

   // conversion timing and count of started conversions
   reg [9:0] conv_cnt_r;
   reg [9:0] conv_cnt_nxt;
   reg [7:0] done_cnt_r;

   // register of the step held next cycle, and its registered decode
   wire [15:0] cur_cfg;
   wire dec_en;
   wire [1:0] dec_gain;
   wire [1:0] dec_neg;
   wire [3:0] dec_pos;

   // reset release through two flip-flops
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_b = rst_sync_r;

   // register writes, reserved bits kept zero
   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         step_two_r <= `STEP_TWO_CFG_RST;
         step_three_r <= `STEP_THREE_CFG_RST;
         run_en_r <= 1'b0;
      end else if (wr_i) begin
         if (addr_i == `STEP_TWO_CFG_ADDR) begin
            step_two_r <= wdata_i & `STEP_CFG_WMASK;
         end
         if (addr_i == `STEP_THREE_CFG_ADDR) begin
            step_three_r <= wdata_i & `STEP_CFG_WMASK;
         end
         if (addr_i == `STEP_CTRL_ADDR) begin
            run_en_r <= wdata_i[0];
         end
      end
   end

   // read data, unmapped reads zero
   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            `STEP_TWO_CFG_ADDR: rdata_o <= step_two_r;
            `STEP_THREE_CFG_ADDR: rdata_o <= step_three_r;
            `STEP_CTRL_ADDR: rdata_o <= {15'h0000, run_en_r};
            `STEP_STATUS_ADDR: rdata_o <= {done_cnt_r, 2'h0, cur_step_r, state_r, 2'h0};
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // decode runs one cycle ahead: fed the step the sequencer holds after
   // this edge, so pick never acts on the settings of the previous step
   // after a skip, a finished conversion or a fresh start from idle
   assign cur_cfg = cur_step_nxt ? step_three_r : step_two_r;

   step_cfg_decode u_decode (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b),
      .cfg_i(cur_cfg),
      .enable_o(dec_en),
      .gain_o(dec_gain),
      .neg_sel_o(dec_neg),
      .pos_sel_o(dec_pos)
   );

   // sequencer: decode settles in pick, then convert or skip
   always @* begin
      state_nxt = state_r;
      cur_step_nxt = cur_step_r;
      conv_cnt_nxt = conv_cnt_r;
      start_nxt = 1'b0;
      case (state_r)
         // idle: wait for run enable, always start at step two
         ST_IDLE: begin
            if (run_en_r) begin
               state_nxt = ST_PICK;
               cur_step_nxt = 1'b0;
            end
         end
         // pick: decode of the current step is settled here
         ST_PICK: begin
            if (dec_en) begin
               state_nxt = ST_CONV; // enabled step converts
               start_nxt = 1'b1;
               conv_cnt_nxt = `CONV_CYCLES - 10'h001;
            end else begin
               cur_step_nxt = ~cur_step_r; // disabled step skipped
               state_nxt = run_en_r ? ST_PICK : ST_IDLE;
            end
         end
         // conv: count down the conversion time, then move to the other step
         ST_CONV: begin
            if (conv_cnt_r == 10'h000) begin
               cur_step_nxt = ~cur_step_r;
               state_nxt = run_en_r ? ST_PICK : ST_IDLE;
            end else begin
               conv_cnt_nxt = conv_cnt_r - 10'h001;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencer registers and converter outputs
   always @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         cur_step_r <= 1'b0;
         conv_cnt_r <= 10'h000;
         done_cnt_r <= 8'h00;
         conv_start_o <= 1'b0;
         conv_gain_o <= `GAIN_X1;
         conv_neg_sel_o <= `NEG_GROUND;
         conv_pos_sel_o <= 4'h0;
         conv_step_o <= 2'h0;
      end else begin
         state_r <= state_nxt;
         cur_step_r <= cur_step_nxt;
         conv_cnt_r <= conv_cnt_nxt;
         conv_start_o <= start_nxt;
         if (start_nxt) begin
            conv_gain_o <= dec_gain; // stored settings applied
            conv_neg_sel_o <= dec_neg;
            conv_pos_sel_o <= dec_pos;
            conv_step_o <= {1'b1, cur_step_r};
            done_cnt_r <= done_cnt_r + 8'h01;
         end
      end
   end

endmodule // mux_adc_sequence_step_cfg

//--- verif/step_cfg_chk.sv
// Purpose: port checker for the step config bank
// Assumes: steps are not rewritten while converting
// Notes: shadows follow host writes to both steps
`timescale 1ns/100ps
`include "step_cfg_map.vh"
module step_cfg_chk (
   // clock, reset, host port
   input wire mclk_i,
   input wire rst_b_i,
   input wire [7:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   // block outputs
   input wire [15:0] rdata_o,
   input wire conv_start_o,
   input wire [1:0] conv_gain_o,
   input wire [1:0] conv_neg_sel_o,
   input wire [3:0] conv_pos_sel_o,
   input wire [1:0] conv_step_o
);
   reg [15:0] two_r;
   reg [15:0] three_r;
   // settings of the step now starting
   wire [15:0] cur = (conv_step_o == 2'h2) ? two_r : three_r;
   wire [1:0] gain = cur[14] ? `GAIN_X4 : {1'b0, cur[13]};
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // shadow copies, reserved bits dropped
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         two_r <= `STEP_TWO_CFG_RST;
         three_r <= `STEP_THREE_CFG_RST;
      end else if (wr_i && addr_i == `STEP_TWO_CFG_ADDR) begin
         two_r <= wdata_i & `STEP_CFG_WMASK;
      end else if (wr_i && addr_i == `STEP_THREE_CFG_ADDR) begin
         three_r <= wdata_i & `STEP_CFG_WMASK;
      end
   end
   two_read_a: assert property ($past(rd_i) && $past(addr_i) == `STEP_TWO_CFG_ADDR
      |-> rdata_o == $past(two_r)) else $error("step two readback wrong");
   three_read_a: assert property ($past(rd_i) && $past(addr_i) == `STEP_THREE_CFG_ADDR
      |-> rdata_o == $past(three_r)) else $error("step three readback wrong");
   start_enabled_a: assert property (conv_start_o |-> cur[15])
      else $error("disabled step converted");
   gain_map_a: assert property (conv_start_o |-> conv_gain_o == gain)
      else $error("gain wrong");
   neg_manual_a: assert property (conv_start_o && !cur[3] |-> conv_neg_sel_o == cur[4])
      else $error("negative input wrong");
   pos_route_a: assert property (conv_start_o |-> conv_pos_sel_o == cur[3:0])
      else $error("positive input wrong");
   neg_auto_a: assert property (conv_start_o && cur[3] |-> conv_neg_sel_o == `NEG_AUTO)
      else $error("negative not automatic");
   start_pulse_a: assert property (conv_start_o |=> !conv_start_o [*8])
      else $error("start not a single pulse");
   cover property (conv_start_o && conv_step_o == 2'h2);
   cover property (conv_start_o && conv_step_o == 2'h3);
   cover property (conv_start_o && cur[3]);
endmodule // step_cfg_chk
bind mux_adc_sequence_step_cfg step_cfg_chk i_chk (.*);

//--- verif/mux_adc_sequence_step_cfg_test.sv
// Purpose: self-checking bench for the step config bank
// Assumes: checker bound beside the block
// Notes: sequencer stopped and restarted for each code
`timescale 1ns/100ps
`include "step_cfg_map.vh"
module mux_adc_sequence_step_cfg_test;
   reg mclk_i = 1'b0;
   reg rst_b_i = 1'b0;
   reg [7:0] addr_i = 8'h00;
   reg [15:0] wdata_i = 16'h0000;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   wire [15:0] rdata_o;
   wire conv_start_o;
   wire [1:0] conv_gain_o;
   wire [1:0] conv_neg_sel_o;
   wire [3:0] conv_pos_sel_o;
   wire [1:0] conv_step_o;
   integer mismatches = 0;
   integer checks = 0;
   integer cycles = 0;
   integer i;
   integer k;
   reg [15:0] cfg [0:3];
   mux_adc_sequence_step_cfg i_dut (.*);
   // 25 MHz clock
   initial begin
      forever #20 mclk_i = ~mclk_i;
   end
   // hang guard
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches = mismatches + 1;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      begin
         if (mismatches == 0 && checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge mclk_i);
         wr_i <= 1'b1;
         addr_i <= a;
         wdata_i <= d;
         @(posedge mclk_i);
         wr_i <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [15:0] exp);
      begin
         @(posedge mclk_i);
         rd_i <= 1'b1;
         addr_i <= a;
         @(posedge mclk_i);
         rd_i <= 1'b0;
         @(negedge mclk_i);
         chk(rdata_o, exp);
      end
   endtask
   // wait for a start, compare with the stored settings of that step
   task conv;
      reg [15:0] c;
      begin
         k = 0;
         @(negedge mclk_i);
         while (conv_start_o !== 1'b1 && k < 200) begin
            @(negedge mclk_i);
            k = k + 1;
         end
         c = cfg[conv_step_o];
         chk({conv_start_o, c[15], conv_gain_o, conv_neg_sel_o, conv_pos_sel_o},
            {2'h3, c[14] ? `GAIN_X4 : {1'b0, c[13]}, c[3] ? `NEG_AUTO : {1'b0, c[4]}, c[3:0]});
      end
   endtask
   // main sequence
   initial begin
      cfg[0] = 16'h0000;
      cfg[1] = 16'h0000;
      repeat (16) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rd(`STEP_TWO_CFG_ADDR, 16'h0002);
      rd(`STEP_THREE_CFG_ADDR, 16'h0003);
      rd(`STEP_CTRL_ADDR, 16'h0000);
      rd(`STEP_STATUS_ADDR, 16'h0004);
      wr(`STEP_THREE_CFG_ADDR, 16'hffff);
      rd(`STEP_THREE_CFG_ADDR, 16'he01f);
      rd(8'h9f, 16'h0000);
      for (i = 0; i < 16; i = i + 1) begin
         cfg[2] = {1'b1, i[1:0], 8'h00, ~i[0], i[3:0]};
         cfg[3] = {1'b1, ~i[1:0], 8'h00, i[1], ~i[3:0]};
         wr(`STEP_TWO_CFG_ADDR, cfg[2]);
         wr(`STEP_THREE_CFG_ADDR, cfg[3]);
         wr(`STEP_CTRL_ADDR, 16'h0001);
         conv;
         conv;
         wr(`STEP_CTRL_ADDR, 16'h0000);
         repeat (40) @(posedge mclk_i);
      end
      cfg[2] = 16'h0015;
      wr(`STEP_TWO_CFG_ADDR, cfg[2]);
      wr(`STEP_CTRL_ADDR, 16'h0001);
      for (i = 0; i < 3; i = i + 1) begin
         conv;
      end
      rd(`STEP_CTRL_ADDR, 16'h0001);
      tally_and_finish;
   end
endmodule // mux_adc_sequence_step_cfg_test
